// [udrt_consts.svh]
// Constants for the up/down auto-reload timer: offsets, fields, reset values and prescaler masks.
`ifndef UDRT_CONSTS_SVH
`define UDRT_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define UDRT_IDX_MODE 16'hFFB4
`define UDRT_IDX_COUNT 16'hFFB5
`define UDRT_IDX_EDGE 16'hFFC0
`define UDRT_IDX_IRQ_REQ 16'hFFC1
`define UDRT_IDX_IRQ_EN 16'hFFC2
`define UDRT_IDX_PORT_MODE 16'hFFC3
`define UDRT_IDX_POWER 16'hFFC4
`define UDRT_BYTE_ADDR(idx) ({14'h0000, idx, 2'b00})

// Mode register fields.
`define UDRT_MODE_RELOAD_BIT 7
`define UDRT_MODE_PIN_DIR_BIT 6
`define UDRT_MODE_SOFT_DIR_BIT 5
`define UDRT_MODE_RES_ONES 8'h18
`define UDRT_MODE_RESET 8'h18

// Single-bit fields of the auxiliary registers.
`define UDRT_EDGE_EVENT_BIT 0
`define UDRT_IRQ_FLAG_BIT 0
`define UDRT_IRQ_EN_BIT 0
`define UDRT_PORT_EVENT_EN_BIT 0
`define UDRT_POWER_SUB_BIT 0

// Reset values and counter limits.
`define UDRT_COUNT_RESET 8'h00
`define UDRT_RELOAD_RESET 8'h00
`define UDRT_COUNT_MAX 8'hFF
`define UDRT_COUNT_MIN 8'h00

// Prescaler tap masks: phi/8192, /2048, /512, /64, /16, /4; last count of the subclock divide-by-four.
`define UDRT_PRE_MASK_8192 13'h1FFF
`define UDRT_PRE_MASK_2048 13'h07FF
`define UDRT_PRE_MASK_512 13'h01FF
`define UDRT_PRE_MASK_64 13'h003F
`define UDRT_PRE_MASK_16 13'h000F
`define UDRT_PRE_MASK_4 13'h0003
`define UDRT_SUB_DIV_LAST 2'h3

`endif

// [udrt_pkg.sv]
// Types shared by the up/down auto-reload timer modules.
package udrt_pkg;

  typedef enum logic [2:0] {
    UDRT_SRC_D8192 = 3'b000,
    UDRT_SRC_D2048 = 3'b001,
    UDRT_SRC_D512 = 3'b010,
    UDRT_SRC_D64 = 3'b011,
    UDRT_SRC_D16 = 3'b100,
    UDRT_SRC_D4 = 3'b101,
    UDRT_SRC_SUB4 = 3'b110,
    UDRT_SRC_EVENT = 3'b111
  } udrt_src_e;

  typedef struct packed {
    logic reload_mode_select;
    logic pin_direction_enable;
    logic soft_direction_select;
    logic [1:0] reserved;
    udrt_src_e clock_source_select;
  } udrt_mode_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } udrt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } udrt_apb_rsp_s;

endpackage

// [udrt_edge_sync.sv]
// Two-stage synchroniser with edge detection for one input pin.
`timescale 1ns/100ps
`include "udrt_consts.svh"
module udrt_edge_sync
  import udrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else if (ce)
    begin
      meta <= din;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign rise = ce & sync & ~last;
  assign fall = ce & ~sync & last;

endmodule // udrt_edge_sync

// [udrt_prescaler.sv]
// Free-running system-clock prescaler and subclock divide-by-four.
`timescale 1ns/100ps
`include "udrt_consts.svh"
module udrt_prescaler
  import udrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic halt,
  input wire logic sub_rise,
  output logic [5:0] phi_tick,
  output logic sub_tick
);

  localparam logic [12:0] TAP_MASK [6] = '{`UDRT_PRE_MASK_8192, `UDRT_PRE_MASK_2048, `UDRT_PRE_MASK_512,
                                           `UDRT_PRE_MASK_64, `UDRT_PRE_MASK_16, `UDRT_PRE_MASK_4};

  logic [12:0] pre_count;
  logic [1:0] sub_count;

  // The system-clock prescaler stops in the subclock modes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_count <= 13'h0000;
    else if (ce && !halt)
      pre_count <= pre_count + 13'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sub_count <= 2'h0;
    else if (ce && sub_rise)
      sub_count <= sub_count + 2'h1;
  end

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_tap
      assign phi_tick[i] = ce & ~halt & ((pre_count & TAP_MASK[i]) == TAP_MASK[i]);
    end
  endgenerate

  assign sub_tick = ce & sub_rise & (sub_count == `UDRT_SUB_DIV_LAST);

endmodule // udrt_prescaler

// [udrt_timer.sv]
// Top level of the 8-bit up/down auto-reload timer with its APB register slave.
//
// Contract
// - Mode register resets to 18 hex.
// - Bit 7 selects interval or auto-reload.
// - Bits 6:5 set direction, or pin.
// - Bits 4 and 3 read one, ignore writes.
// - Three-bit select picks one of eight sources.
// - Event counting uses the selected edge only.
// - Read-only 8-bit counter steps by one.
// - Counter readable anytime without disturbing it.
// - Up-count past FF sets overflow flag.
// - Down-count past 00 sets same flag.
// - Shared address: read counter, write reload.
// - Reset clears the counter.
// - Reload register write-only, reset to zero.
// - Subclock modes count only subclock or event.
// - Reload write loads counter immediately too.
// - Auto-reload mode reloads on every wrap.
// - Interval mode wraps to 00 or FF.
// - Interrupt requested when flag and enable set.
`timescale 1ns/100ps
`include "udrt_consts.svh"
module udrt_timer
  import udrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire udrt_apb_req_s apb_req,
  output udrt_apb_rsp_s apb_rsp,
  input wire logic event_input_pin,
  input wire logic direction_input_pin,
  input wire logic subclk_in,
  output logic irq_out
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------

  udrt_mode_s mode_control_reg;
  logic [7:0] count_value_reg;
  logic [7:0] reload_value_reg;
  logic event_edge_select;
  logic overflow_request_flag;
  logic overflow_irq_enable;
  logic event_pin_function_enable;
  logic sub_mode;
  logic [31:0] prdata;
  logic pslverr;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------

  logic event_rise;
  logic event_fall;
  logic dir_level;
  logic sub_rise;

  udrt_edge_sync u_event_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(event_input_pin),
    .level(),
    .rise(event_rise),
    .fall(event_fall)
  );

  udrt_edge_sync u_dir_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(direction_input_pin),
    .level(dir_level),
    .rise(),
    .fall()
  );

  udrt_edge_sync u_sub_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(subclk_in),
    .level(),
    .rise(sub_rise),
    .fall()
  );

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------

  logic [5:0] phi_tick;
  logic sub_tick;

  udrt_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .halt(sub_mode),
    .sub_rise(sub_rise),
    .phi_tick(phi_tick),
    .sub_tick(sub_tick)
  );

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------

  wire logic setup_phase;
  wire logic access_phase;
  wire logic wr_en;
  wire logic hit_mode;
  wire logic hit_count;
  wire logic hit_edge;
  wire logic hit_irq_req;
  wire logic hit_irq_en;
  wire logic hit_port_mode;
  wire logic hit_power;
  wire logic hit_any;
  wire logic [7:0] wbyte;

  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_en = access_phase & apb_req.pwrite & ce;
  assign hit_mode = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_MODE);
  assign hit_count = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_COUNT);
  assign hit_edge = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_EDGE);
  assign hit_irq_req = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_IRQ_REQ);
  assign hit_irq_en = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_IRQ_EN);
  assign hit_port_mode = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_PORT_MODE);
  assign hit_power = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_POWER);
  assign hit_any = hit_mode | hit_count | hit_edge | hit_irq_req | hit_irq_en | hit_port_mode | hit_power;
  assign wbyte = apb_req.pwdata[7:0];

  wire logic wr_mode;
  wire logic wr_reload;
  wire logic wr_edge;
  wire logic wr_irq_req;
  wire logic wr_irq_en;
  wire logic wr_port_mode;
  wire logic wr_power;

  assign wr_mode = wr_en & hit_mode;
  assign wr_reload = wr_en & hit_count;
  assign wr_edge = wr_en & hit_edge;
  assign wr_irq_req = wr_en & hit_irq_req;
  assign wr_irq_en = wr_en & hit_irq_en;
  assign wr_port_mode = wr_en & hit_port_mode;
  assign wr_power = wr_en & hit_power;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------

  wire logic [7:0] mode_readback;
  wire logic [7:0] next_rbyte;
  wire logic [31:0] next_prdata;

  // Reserved bits always read as one.
  assign mode_readback = mode_control_reg | `UDRT_MODE_RES_ONES;
  // The counter is read from its flops with no side effect on counting.
  assign next_rbyte = hit_mode ? mode_readback :
                      hit_count ? count_value_reg :
                      hit_edge ? {7'h00, event_edge_select} :
                      hit_irq_req ? {7'h00, overflow_request_flag} :
                      hit_irq_en ? {7'h00, overflow_irq_enable} :
                      hit_port_mode ? {7'h00, event_pin_function_enable} :
                      hit_power ? {7'h00, sub_mode} :
                      8'h00;
  assign next_prdata = {24'h000000, next_rbyte};

  // Read data and error are captured in the setup cycle for a zero-wait access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce && setup_phase)
    begin
      prdata <= apb_req.pwrite ? 32'h00000000 : next_prdata;
      pslverr <= ~hit_any;
    end
  end

  assign apb_rsp.prdata = prdata;
  assign apb_rsp.pready = ce;
  assign apb_rsp.pslverr = pslverr & access_phase;

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------

  // Only bits 7:5 and 2:0 are writable; bits 4:3 hold their reset ones.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_control_reg <= udrt_mode_s'(`UDRT_MODE_RESET);
    else if (wr_mode)
    begin
      mode_control_reg.reload_mode_select <= wbyte[`UDRT_MODE_RELOAD_BIT];
      mode_control_reg.pin_direction_enable <= wbyte[`UDRT_MODE_PIN_DIR_BIT];
      mode_control_reg.soft_direction_select <= wbyte[`UDRT_MODE_SOFT_DIR_BIT];
      mode_control_reg.clock_source_select <= udrt_src_e'(wbyte[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_value_reg <= `UDRT_RELOAD_RESET;
    else if (wr_reload)
      reload_value_reg <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_edge_select <= 1'b0;
      overflow_irq_enable <= 1'b0;
      event_pin_function_enable <= 1'b0;
      sub_mode <= 1'b0;
    end
    else
    begin
      if (wr_edge)
        event_edge_select <= wbyte[`UDRT_EDGE_EVENT_BIT];
      if (wr_irq_en)
        overflow_irq_enable <= wbyte[`UDRT_IRQ_EN_BIT];
      if (wr_port_mode)
        event_pin_function_enable <= wbyte[`UDRT_PORT_EVENT_EN_BIT];
      if (wr_power)
        sub_mode <= wbyte[`UDRT_POWER_SUB_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Count source selection
  // ---------------------------------------------------------------------------

  wire logic event_edge;
  wire logic src_low_power_ok;
  logic src_tick;
  logic count_tick;

  // Event pulses pass only with the pin function enabled, on the chosen edge.
  assign event_edge = event_pin_function_enable & (event_edge_select ? event_rise : event_fall);

  always_comb
  begin
    src_tick = 1'b0;
    unique case (mode_control_reg.clock_source_select)
      UDRT_SRC_D8192: src_tick = phi_tick[0];
      UDRT_SRC_D2048: src_tick = phi_tick[1];
      UDRT_SRC_D512: src_tick = phi_tick[2];
      UDRT_SRC_D64: src_tick = phi_tick[3];
      UDRT_SRC_D16: src_tick = phi_tick[4];
      UDRT_SRC_D4: src_tick = phi_tick[5];
      UDRT_SRC_SUB4: src_tick = sub_tick;
      UDRT_SRC_EVENT: src_tick = event_edge;
    endcase
  end

  // In the subclock modes only the subclock and event sources keep counting.
  assign src_low_power_ok = (mode_control_reg.clock_source_select == UDRT_SRC_SUB4) ||
                            (mode_control_reg.clock_source_select == UDRT_SRC_EVENT);

  always_comb
  begin
    count_tick = src_tick & (~sub_mode | src_low_power_ok);
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------

  wire logic count_down;
  wire logic overflow;
  wire logic underflow;
  wire logic wrap;
  logic [7:0] next_count;

  assign count_down = mode_control_reg.pin_direction_enable ? dir_level :
                      mode_control_reg.soft_direction_select;
  assign overflow = count_tick & ~count_down & (count_value_reg == `UDRT_COUNT_MAX);
  assign underflow = count_tick & count_down & (count_value_reg == `UDRT_COUNT_MIN);
  assign wrap = overflow | underflow;

  // A reload write takes priority over a coincident count pulse.
  always_comb
  begin
    next_count = count_value_reg;
    if (wr_reload)
      next_count = wbyte;
    else if (wrap && mode_control_reg.reload_mode_select)
      next_count = reload_value_reg;
    else if (overflow)
      next_count = `UDRT_COUNT_MIN;
    else if (underflow)
      next_count = `UDRT_COUNT_MAX;
    else if (count_tick && count_down)
      next_count = count_value_reg - 8'h01;
    else if (count_tick)
      next_count = count_value_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_reg <= `UDRT_COUNT_RESET;
    else if (ce)
      count_value_reg <= next_count;
  end

  // ---------------------------------------------------------------------------
  // Overflow request flag and interrupt
  // ---------------------------------------------------------------------------

  wire logic flag_clear;
  wire logic next_flag;

  // Writing zero clears the flag; a wrap in the same cycle wins.
  assign flag_clear = wr_irq_req & ~wbyte[`UDRT_IRQ_FLAG_BIT];
  assign next_flag = wrap | (overflow_request_flag & ~flag_clear);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_request_flag <= 1'b0;
    else if (ce)
      overflow_request_flag <= next_flag;
  end

  assign irq_out = overflow_request_flag & overflow_irq_enable;

endmodule // udrt_timer

// [udrt_timer_properties.sv]
// Concurrent checks on the timer ports, bound to the top module.
`timescale 1ns/100ps
`include "udrt_consts.svh"
module udrt_timer_checker
  import udrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire udrt_apb_req_s apb_req,
  input wire udrt_apb_rsp_s apb_rsp,
  input wire logic event_input_pin,
  input wire logic direction_input_pin,
  input wire logic subclk_in,
  input wire logic irq_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Shadow copies of the mode and enable registers
  // ----------------------------------------
  logic [7:0] mode;
  logic en;
  wire acc = apb_req.psel && apb_req.penable && ce;
  wire setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite && ce;
  wire at_mode = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_MODE);
  wire at_cnt = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_COUNT);
  wire at_en = apb_req.paddr == `UDRT_BYTE_ADDR(`UDRT_IDX_IRQ_EN);
  wire wr_mode = acc && apb_req.pwrite && at_mode;
  wire wr_en = acc && apb_req.pwrite && at_en;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= 8'h18;
      en <= 1'b0;
    end
    else if (wr_mode)
      mode <= apb_req.pwdata[7:0] | 8'h18;
    else if (wr_en)
      en <= apb_req.pwdata[0];
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mode_readback: assert property (setup_rd && at_mode |=> apb_rsp.prdata == {24'h0, mode})
    else $error("mode register read data wrong");
  a_reserved_ones: assert property (setup_rd && at_mode |=> apb_rsp.prdata[4:3] == 2'b11)
    else $error("reserved mode bits not read as one");
  a_count_width: assert property (setup_rd && at_cnt |=> apb_rsp.prdata[31:8] == 24'h0)
    else $error("count read wider than eight bits");
  a_irq_needs_en: assert property (irq_out |-> en)
    else $error("interrupt raised while disabled");
  a_irq_off: assert property (wr_en && !apb_req.pwdata[0] |=> !irq_out)
    else $error("interrupt still high after disable");
  a_read_hold: assert property (acc |=> $stable(apb_rsp.prdata))
    else $error("read data changed after access");
  a_ready_ce: assert property (apb_rsp.pready == ce)
    else $error("ready does not follow clock enable");
  a_err_access: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("error response outside access phase");
  cover property (setup_rd && at_cnt);
  cover property ($rose(irq_out));
  cover property (apb_rsp.pslverr);
endmodule // udrt_timer_checker

bind udrt_timer udrt_timer_checker u_udrt_timer_checker (.pclk(pclk), .presetn(presetn), .ce(ce),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .event_input_pin(event_input_pin),
  .direction_input_pin(direction_input_pin), .subclk_in(subclk_in), .irq_out(irq_out));

// [udrt_partner.sv]
// Model of the external event source, direction pin and free-running subclock.
`timescale 1ns/100ps
module udrt_partner
  import udrt_pkg::*;
(
  input wire logic pclk,
  input wire logic start,
  input wire logic [3:0] toggles,
  input wire logic dir_down,
  output logic event_input_pin,
  output logic direction_input_pin,
  output logic subclk_in
);
  logic [3:0] left;
  logic [2:0] gap;
  initial
  begin
    event_input_pin = 1'b0;
    subclk_in = 1'b0;
    left = 4'h0;
    gap = 3'h0;
  end
  // High selects down-counting when the pin decides direction.
  assign direction_input_pin = dir_down;
  // Edges are eight cycles apart so each one survives synchronisation.
  always @(posedge pclk)
  begin
    gap <= gap + 3'h1;
    if (gap == 3'h7)
      subclk_in <= ~subclk_in;
    if (start)
      left <= toggles;
    else if (left != 4'h0 && gap == 3'h7)
    begin
      event_input_pin <= ~event_input_pin;
      left <= left - 4'h1;
    end
  end
endmodule // udrt_partner

// [udrt_timer_tb.sv]
// Self-checking testbench for the up/down auto-reload timer.
`timescale 1ns/100ps
`include "udrt_consts.svh"
module udrt_timer_tb
  import udrt_pkg::*;
;
  logic pclk, presetn, ce, start, dir_down, err;
  logic [3:0] toggles;
  logic [31:0] rdata;
  udrt_apb_req_s apb_req;
  udrt_apb_rsp_s apb_rsp;
  logic event_input_pin, direction_input_pin, subclk_in, irq_out;
  int mismatches, comparisons;
  udrt_timer u_udrt_timer (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .event_input_pin(event_input_pin), .direction_input_pin(direction_input_pin),
    .subclk_in(subclk_in), .irq_out(irq_out));
  udrt_partner u_udrt_partner (.pclk(pclk), .start(start), .toggles(toggles), .dir_down(dir_down),
    .event_input_pin(event_input_pin), .direction_input_pin(direction_input_pin), .subclk_in(subclk_in));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= `UDRT_BYTE_ADDR(idx);
    apb_req.pwdata <= {24'h0, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic wait_flag;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `UDRT_IDX_IRQ_REQ, 8'h00);
      n++;
    end
    while (rdata[0] !== 1'b1 && n < 2000);
    chk(rdata, 32'h1);
  endtask
  task automatic burst(input logic dn, input logic [3:0] n);
    dir_down <= dn;
    toggles <= n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (60) @(posedge pclk);
  endtask
  // Counts the steps of one source between two reads that are gap plus three enabled cycles apart.
  // A nonzero frz holds the clock enable low for that many cycles in between.
  task automatic rate(input logic [7:0] sel, input int gap, input int frz, input logic [7:0] steps);
    logic [7:0] first;
    wr(`UDRT_IDX_MODE, sel);
    apb(1'b0, `UDRT_IDX_COUNT, 8'h00);
    first = rdata[7:0];
    if (frz > 0)
    begin
      ce <= 1'b0;
      repeat (frz) @(posedge pclk);
      chk({31'h0, apb_rsp.pready}, 32'h0);
      ce <= 1'b1;
    end
    repeat (gap) @(posedge pclk);
    apb(1'b0, `UDRT_IDX_COUNT, 8'h00);
    chk({24'h0, rdata[7:0] - first}, {24'h0, steps});
  endtask
  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    mismatches++;
    close_out;
  end
  initial
  begin
    apb_req = '0;
    presetn = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    toggles = 4'h0;
    dir_down = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`UDRT_IDX_MODE, 32'h18);
    rd(`UDRT_IDX_COUNT, 32'h0);
    wr(`UDRT_IDX_MODE, 8'h00);
    rd(`UDRT_IDX_MODE, 32'h18);
    apb(1'b0, 16'hFFB0, 8'h00);
    chk({31'h0, err}, 32'h1);
    wr(`UDRT_IDX_COUNT, 8'h42);
    rd(`UDRT_IDX_COUNT, 32'h42);
    $display("reset and access test done");
    wr(`UDRT_IDX_IRQ_EN, 8'h01);
    wr(`UDRT_IDX_MODE, 8'h03);
    wr(`UDRT_IDX_COUNT, 8'hFF);
    wait_flag;
    chk({31'h0, irq_out}, 32'h1);
    rd(`UDRT_IDX_COUNT, 32'h0);
    wr(`UDRT_IDX_IRQ_EN, 8'h00);
    chk({31'h0, irq_out}, 32'h0);
    wr(`UDRT_IDX_IRQ_REQ, 8'h00);
    rd(`UDRT_IDX_IRQ_REQ, 32'h0);
    $display("interval overflow test done");
    wr(`UDRT_IDX_MODE, 8'hA3);
    wr(`UDRT_IDX_COUNT, 8'h10);
    wait_flag;
    rd(`UDRT_IDX_COUNT, 32'h10);
    wr(`UDRT_IDX_IRQ_REQ, 8'h00);
    wr(`UDRT_IDX_MODE, 8'h23);
    wr(`UDRT_IDX_COUNT, 8'h00);
    wait_flag;
    rd(`UDRT_IDX_COUNT, 32'hFF);
    wr(`UDRT_IDX_IRQ_REQ, 8'h00);
    $display("down count test done");
    wr(`UDRT_IDX_PORT_MODE, 8'h01);
    wr(`UDRT_IDX_EDGE, 8'h01);
    wr(`UDRT_IDX_MODE, 8'h47);
    wr(`UDRT_IDX_COUNT, 8'h20);
    burst(1'b1, 4'd5);
    rd(`UDRT_IDX_COUNT, 32'h1D);
    wr(`UDRT_IDX_EDGE, 8'h00);
    burst(1'b0, 4'd4);
    rd(`UDRT_IDX_COUNT, 32'h1F);
    $display("event count test done");
    rate(8'h00, 8189, 0, 8'h01);
    rate(8'h01, 2045, 0, 8'h01);
    rate(8'h02, 509, 0, 8'h01);
    rate(8'h03, 61, 0, 8'h01);
    rate(8'h04, 61, 0, 8'h04);
    rate(8'h05, 61, 64, 8'h10);
    $display("prescaler rate test done");
    wr(`UDRT_IDX_POWER, 8'h01);
    wr(`UDRT_IDX_MODE, 8'h05);
    wr(`UDRT_IDX_COUNT, 8'h55);
    repeat (100) @(posedge pclk);
    rd(`UDRT_IDX_COUNT, 32'h55);
    wr(`UDRT_IDX_MODE, 8'h06);
    repeat (300) @(posedge pclk);
    apb(1'b0, `UDRT_IDX_COUNT, 8'h00);
    chk({31'h0, rdata[7:0] != 8'h55}, 32'h1);
    rate(8'h06, 61, 0, 8'h01);
    $display("subclock test done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`UDRT_IDX_MODE, 32'h18);
    rd(`UDRT_IDX_COUNT, 32'h0);
    wr(`UDRT_IDX_MODE, 8'hA5);
    repeat (20) @(posedge pclk);
    rd(`UDRT_IDX_COUNT, 32'h0);
    rd(`UDRT_IDX_IRQ_REQ, 32'h1);
    $display("mid-run reset test done");
    close_out;
  end
endmodule // udrt_timer_tb
